// File: eirq_defs.svh
// Register offsets, field positions, reset values and timing counts of the pin flag block
`ifndef EIRQ_DEFS_SVH
`define EIRQ_DEFS_SVH

// Register byte offsets
`define EIRQ_OFF_PFSEL 8'h00
`define EIRQ_OFF_PFSEL0 8'h04
`define EIRQ_OFF_WKSEL 8'h08
`define EIRQ_OFF_IEDGE 8'h0c
`define EIRQ_OFF_WEDGE 8'h10
`define EIRQ_OFF_IFLAG 8'h14
`define EIRQ_OFF_WFLAG 8'h18
`define EIRQ_OFF_EVSTAT 8'h1c
`define EIRQ_OFF_EVMASK 8'h20

// Field positions
`define EIRQ_IRQ0_BIT 0
`define EIRQ_IRQ_HI 4
`define EIRQ_WK_HI 7
`define EIRQ_EV_IRQ_LO 0
`define EIRQ_EV_WK_LO 5
`define EIRQ_EV_HI 12

// Reset values
`define EIRQ_RST_SEL 8'h00
`define EIRQ_RST_EDGE 8'h00
`define EIRQ_RST_FLAG 8'h00
`define EIRQ_RST_EV 13'h0000
`define EIRQ_RST_PIN 8'hff

// Timing counts in pclk cycles
`define EIRQ_SYNC_STAGES 3
`define EIRQ_APB_WAIT 1

`endif

// File: eirq_pkg.sv
// Types shared by the pin flag block
package eirq_pkg;

	typedef logic [7:0] eirq_addr_t;
	typedef logic [31:0] eirq_data_t;

	typedef struct packed {
		logic [4:0] irq_s1;
		logic [4:0] irq_s2;
		logic [4:0] irq_s3;
		logic [4:0] irq_flt;
		logic [4:0] irq_eff_prev;
		logic [7:0] wk_s1;
		logic [7:0] wk_s2;
		logic [7:0] wk_s3;
		logic [7:0] wk_flt;
		logic [7:0] wk_flt_prev;
		logic [4:1] irq_sel;
		logic irq0_sel;
		logic [7:0] wk_sel;
		logic [4:0] irq_edge;
		logic [7:0] wk_edge;
		logic [4:0] irq_flag;
		logic [7:0] wk_flag;
		logic [12:0] ev_stat;
		logic [12:0] ev_mask;
		logic pcfg_last;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic irq;
	} eirq_state_t;

endpackage

// File: eirq_pin_flags.sv
// External interrupt and wakeup pin request flags with an APB register file
`timescale 1ns/1ps
`include "eirq_defs.svh"

// Summary of operation
// - Select 0 to 1 with pin low and falling edge chosen sets the irq flag
// - Select 1 to 0 with pin low and rising edge chosen sets the irq flag
// - Pins 1 to 4 selected in one register, pin 0 in another
// - Wakeup select 0 to 1 with pin low sets the wakeup flag
// - Flag clear right after a port select access is ignored
// - Pin held high during select change sets no flag
// - Flag write clears bits written 0, keeps bits written 1
// - Writing 0 clears a flag even if set after the last read
// - Irq pin n flag sits at bit n of the irq flag register
// - Wakeup edge bit 0 detects falling, 1 detects rising
// - Wakeup flags reset to 0 and clear on a written 0
module eirq_pin_flags (
	input wire logic pclk, // System clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire eirq_pkg::eirq_addr_t paddr, // APB byte address
	input wire eirq_pkg::eirq_data_t pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [4:0] irq_pin_n, // Edge interrupt pins, asynchronous
	input wire logic [7:0] wakeup_pin_n, // Wakeup pins, asynchronous
	output logic irq_out // Level interrupt
);
	import eirq_pkg::*;

	localparam eirq_state_t EIRQ_RST = '{
		irq_s1: 5'(`EIRQ_RST_PIN),
		irq_s2: 5'(`EIRQ_RST_PIN),
		irq_s3: 5'(`EIRQ_RST_PIN),
		irq_flt: 5'(`EIRQ_RST_PIN),
		irq_eff_prev: 5'(`EIRQ_RST_PIN),
		wk_s1: `EIRQ_RST_PIN,
		wk_s2: `EIRQ_RST_PIN,
		wk_s3: `EIRQ_RST_PIN,
		wk_flt: `EIRQ_RST_PIN,
		wk_flt_prev: `EIRQ_RST_PIN,
		irq_sel: 4'(`EIRQ_RST_SEL),
		irq0_sel: 1'b0,
		wk_sel: `EIRQ_RST_SEL,
		irq_edge: 5'(`EIRQ_RST_EDGE),
		wk_edge: `EIRQ_RST_EDGE,
		irq_flag: 5'(`EIRQ_RST_FLAG),
		wk_flag: `EIRQ_RST_FLAG,
		ev_stat: `EIRQ_RST_EV,
		ev_mask: `EIRQ_RST_EV,
		default: '0
	};

	// A filtered level follows the third stage only when the second agrees
	function automatic logic [7:0] eirq_filter(input logic [7:0] s2, input logic [7:0] s3,
		input logic [7:0] flt);
		eirq_filter = (s2 & s3) | (flt & (s2 | s3));
	endfunction

	// Write-zero clear of a flag byte; a set in the same cycle wins
	function automatic logic [7:0] eirq_clr0(input logic [7:0] old, input logic [7:0] wdat,
		input logic do_clr, input logic [7:0] set);
		eirq_clr0 = (do_clr ? (old & wdat) : old) | set;
	endfunction

	eirq_state_t st_ff;
	eirq_state_t nxt_st;

	logic acc;
	logic wr;
	logic mapped;
	logic pcfg_hit;
	logic [4:0] irq_eff;
	logic [4:0] irq_hit;
	logic [7:0] wk_hit;
	logic [7:0] wk_spur;
	logic [7:0] wk_sel_new;
	logic [7:0] irq_flt8;
	logic [7:0] irq_flag8;
	logic [7:0] wk_flag8;
	logic [12:0] ev_set;
	logic flag_clr_ok;
	logic [31:0] rdat;

	// Combined next state
	always_comb begin
		nxt_st = st_ff;
		acc = psel & penable & st_ff.pready;
		wr = acc & pwrite;

		// Three stage pin synchronisers with agreement filter
		nxt_st.irq_s1 = irq_pin_n;
		nxt_st.irq_s2 = st_ff.irq_s1;
		nxt_st.irq_s3 = st_ff.irq_s2;
		irq_flt8 = eirq_filter({3'h0, st_ff.irq_s2}, {3'h0, st_ff.irq_s3},
			{3'h0, st_ff.irq_flt});
		nxt_st.irq_flt = irq_flt8[4:0];
		nxt_st.wk_s1 = wakeup_pin_n;
		nxt_st.wk_s2 = st_ff.wk_s1;
		nxt_st.wk_s3 = st_ff.wk_s2;
		nxt_st.wk_flt = eirq_filter(st_ff.wk_s2, st_ff.wk_s3, st_ff.wk_flt);
		nxt_st.wk_flt_prev = st_ff.wk_flt;

		// Effective irq input is held high while the pin is not selected
		irq_eff = ~{st_ff.irq_sel, st_ff.irq0_sel} | st_ff.irq_flt;
		nxt_st.irq_eff_prev = irq_eff;
		// Select changes appear as edges on the effective input
		irq_hit = (~st_ff.irq_edge & st_ff.irq_eff_prev & ~irq_eff)
			| (st_ff.irq_edge & ~st_ff.irq_eff_prev & irq_eff);

		// Real wakeup edges on a selected pin, direction per edge bit
		wk_hit = st_ff.wk_sel & ((st_ff.wk_edge & ~st_ff.wk_flt_prev & st_ff.wk_flt)
			| (~st_ff.wk_edge & st_ff.wk_flt_prev & ~st_ff.wk_flt));

		// Address decode
		mapped = 1'b1;
		case (paddr)
			`EIRQ_OFF_PFSEL, `EIRQ_OFF_PFSEL0, `EIRQ_OFF_WKSEL, `EIRQ_OFF_IEDGE,
			`EIRQ_OFF_WEDGE, `EIRQ_OFF_IFLAG, `EIRQ_OFF_WFLAG, `EIRQ_OFF_EVSTAT,
			`EIRQ_OFF_EVMASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
		pcfg_hit = (paddr == `EIRQ_OFF_PFSEL) | (paddr == `EIRQ_OFF_PFSEL0)
			| (paddr == `EIRQ_OFF_WKSEL);

		// Wakeup select 0 to 1 while the pin is low sets a flag at once
		wk_sel_new = (wr && paddr == `EIRQ_OFF_WKSEL) ? pwdata[7:0] : st_ff.wk_sel;
		wk_spur = ~st_ff.wk_sel & wk_sel_new & ~st_ff.wk_flt;

		// Plain control register writes
		if (wr) begin
			case (paddr)
				`EIRQ_OFF_PFSEL: nxt_st.irq_sel = pwdata[4:1];
				`EIRQ_OFF_PFSEL0: nxt_st.irq0_sel = pwdata[`EIRQ_IRQ0_BIT];
				`EIRQ_OFF_WKSEL: nxt_st.wk_sel = pwdata[7:0];
				`EIRQ_OFF_IEDGE: nxt_st.irq_edge = pwdata[4:0];
				`EIRQ_OFF_WEDGE: nxt_st.wk_edge = pwdata[7:0];
				`EIRQ_OFF_EVMASK: nxt_st.ev_mask = pwdata[12:0];
				default: ;
			endcase
		end

		// A clear right after a select access is dropped
		flag_clr_ok = wr & ~st_ff.pcfg_last;
		if (acc) begin
			nxt_st.pcfg_last = pcfg_hit;
		end

		// Flag registers, bit n for pin n, write-zero clear, set wins
		irq_flag8 = eirq_clr0({3'h0, st_ff.irq_flag}, pwdata[7:0],
			flag_clr_ok && paddr == `EIRQ_OFF_IFLAG, {3'h0, irq_hit});
		nxt_st.irq_flag = irq_flag8[4:0];
		wk_flag8 = eirq_clr0(st_ff.wk_flag, pwdata[7:0],
			flag_clr_ok && paddr == `EIRQ_OFF_WFLAG, wk_hit | wk_spur);
		nxt_st.wk_flag = wk_flag8;

		// Sticky event status, write-one clear, set wins
		ev_set = {wk_hit | wk_spur, irq_hit};
		nxt_st.ev_stat = st_ff.ev_stat;
		if (wr && paddr == `EIRQ_OFF_EVSTAT) begin
			nxt_st.ev_stat = st_ff.ev_stat & ~pwdata[12:0];
		end
		nxt_st.ev_stat = nxt_st.ev_stat | ev_set;
		nxt_st.irq = |(nxt_st.ev_stat & nxt_st.ev_mask);

		// Read data
		case (paddr)
			`EIRQ_OFF_PFSEL: rdat = {27'h0, st_ff.irq_sel, 1'b0};
			`EIRQ_OFF_PFSEL0: rdat = {31'h0, st_ff.irq0_sel};
			`EIRQ_OFF_WKSEL: rdat = {24'h0, st_ff.wk_sel};
			`EIRQ_OFF_IEDGE: rdat = {27'h0, st_ff.irq_edge};
			`EIRQ_OFF_WEDGE: rdat = {24'h0, st_ff.wk_edge};
			`EIRQ_OFF_IFLAG: rdat = {27'h0, st_ff.irq_flag};
			`EIRQ_OFF_WFLAG: rdat = {24'h0, st_ff.wk_flag};
			`EIRQ_OFF_EVSTAT: rdat = {19'h0, st_ff.ev_stat};
			`EIRQ_OFF_EVMASK: rdat = {19'h0, st_ff.ev_mask};
			default: rdat = 32'h0;
		endcase

		// One wait state, answer registered in the first access cycle
		nxt_st.pready = psel & penable & ~st_ff.pready;
		nxt_st.pslverr = psel & penable & ~st_ff.pready & ~mapped;
		if (psel & penable & ~st_ff.pready) begin
			nxt_st.prdata = pwrite ? 32'h0 : rdat;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= EIRQ_RST;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign irq_out = st_ff.irq;

endmodule // eirq_pin_flags

// File: eirq_pin_flags_sva.sv
// Port checker for the pin flag block
`timescale 1ns/1ps
module eirq_pin_flags_sva (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // Select
	input wire logic penable, // Access
	input wire logic pwrite, // Write
	input wire eirq_pkg::eirq_addr_t paddr, // Address
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic [4:0] irq_pin_n, // Irq pins
	input wire logic [7:0] wakeup_pin_n, // Wakeup pins
	input wire logic irq_out // Interrupt
);
	import eirq_pkg::*;
	logic [3:0] age_ff;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Cycles since the last pin change or completed write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) age_ff <= 4'h0;
		else if ($changed({irq_pin_n, wakeup_pin_n}) || (pready && pwrite)) age_ff <= 4'h0;
		else if (age_ff != 4'hf) age_ff <= age_ff + 4'h1;
	end
	property p_ready; psel && penable && !pready |=> pready ##1 !pready; endproperty
	property p_idle; !psel |=> !pready; endproperty
	property p_err; pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h20); endproperty
	property p_errdat; pslverr && !pwrite |-> prdata == 32'h0; endproperty
	property p_ifl; pready && !pwrite && paddr == 8'h14 |-> prdata[31:5] == 27'h0; endproperty
	property p_wfl; pready && !pwrite && paddr == 8'h18 |-> prdata[31:8] == 24'h0; endproperty
	property p_rose; $rose(irq_out) |-> age_ff < 4'hc; endproperty
	property p_fell; $fell(irq_out) |-> age_ff < 4'h3; endproperty
	a_ready: assert property (p_ready) else $error("pready not one pulse");
	a_idle: assert property (p_idle) else $error("pready without select");
	a_err: assert property (p_err) else $error("pslverr wrong");
	a_errdat: assert property (p_errdat) else $error("unmapped read not zero");
	a_ifl: assert property (p_ifl) else $error("irq flag read wide");
	a_wfl: assert property (p_wfl) else $error("wakeup flag read wide");
	a_rose: assert property (p_rose) else $error("irq without cause");
	a_fell: assert property (p_fell) else $error("irq fell without write");
	c_err: cover property (pready && pslverr);
	c_irq: cover property ($rose(irq_out));
	c_flag: cover property (pready && !pwrite && paddr == 8'h18 && prdata != 32'h0);
endmodule // eirq_pin_flags_sva
bind eirq_pin_flags eirq_pin_flags_sva u_eirq_pin_flags_sva (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .irq_pin_n, .wakeup_pin_n, .irq_out);

// File: eirq_pin_model.sv
// Pin driver standing in for the external interrupt sources
`timescale 1ns/1ps
module eirq_pin_model (
	input wire logic pclk, // Clock pacing pin changes
	input wire logic slow, // Change only every other edge
	input wire logic [12:0] want, // Requested levels
	output logic [12:0] pins // Pin levels, idle high
);
	logic odd_ff;
	initial begin
		pins = 13'h1fff;
		odd_ff = 1'b0;
	end
	// Levels follow the request, late when slow
	always @(posedge pclk) begin
		odd_ff <= !odd_ff;
		if (!slow || odd_ff) pins <= want;
	end
endmodule // eirq_pin_model

// File: eirq_pin_flags_test.sv
// Self-checking bench for the pin flag block
`timescale 1ns/1ps
`include "eirq_defs.svh"
module eirq_pin_flags_test;
	import eirq_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_out, slow;
	eirq_addr_t paddr;
	eirq_data_t pwdata, r;
	logic [31:0] prdata;
	logic [12:0] want, pins;
	int failures, compares;
	eirq_data_t eq[$];
	string nq[$];
	eirq_addr_t sel[3] = '{`EIRQ_OFF_PFSEL, `EIRQ_OFF_PFSEL0, `EIRQ_OFF_WKSEL};
	eirq_pin_flags u_eirq_pin_flags (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .irq_pin_n(pins[4:0]), .wakeup_pin_n(pins[12:5]),
		.irq_out);
	eirq_pin_model u_eirq_pin_model (.pclk, .slow, .want, .pins);
	// Clock at 25 MHz
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic check(string n, eirq_data_t got, eirq_data_t exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic stop_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// One transfer, held until pready is sampled high
	task automatic xfer(eirq_addr_t a, logic w, eirq_data_t d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(eirq_addr_t a, eirq_data_t e, string n);
		eq.push_back(e);
		nq.push_back(n);
		xfer(a, 1'b0, 32'h0);
	endtask
	// Compare each completed read with the oldest note
	always @(posedge pclk) begin
		if (pready === 1'b1 && pwrite === 1'b0) begin
			check(nq.pop_front(), prdata, eq.pop_front());
		end
	end
	// Watchdog
	initial begin
		repeat (3000) @(posedge pclk);
		failures++;
		stop_test();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, slow} = '0;
		presetn = 1'b0;
		want = 13'h1fff;
		void'($urandom(80));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		for (int a = 0; a <= 'h24; a += 4) rd(8'(a), 32'h0, "reset");
		$display("test reset done");
		foreach (sel[i]) xfer(sel[i], 1'b1, 32'hff);
		rd(`EIRQ_OFF_IFLAG, 32'h0, "high");
		rd(`EIRQ_OFF_WFLAG, 32'h0, "high");
		foreach (sel[i]) xfer(sel[i], 1'b1, 32'h0);
		$display("test high done");
		want <= 13'h0;
		repeat (8) @(posedge pclk);
		r = $urandom & 32'hff | 32'h81;
		foreach (sel[i]) xfer(sel[i], 1'b1, r);
		xfer(`EIRQ_OFF_WFLAG, 1'b1, 32'h0);
		rd(`EIRQ_OFF_WFLAG, r, "keep");
		xfer(`EIRQ_OFF_IFLAG, 1'b1, 32'hfd);
		rd(`EIRQ_OFF_IFLAG, r & 32'h1d, "bit1");
		xfer(`EIRQ_OFF_WFLAG, 1'b1, 32'h0);
		rd(`EIRQ_OFF_WFLAG, 32'h0, "clear");
		xfer(`EIRQ_OFF_IEDGE, 1'b1, 32'h1f);
		xfer(`EIRQ_OFF_IFLAG, 1'b1, 32'h0);
		xfer(`EIRQ_OFF_PFSEL, 1'b1, 32'h0);
		xfer(`EIRQ_OFF_PFSEL0, 1'b1, 32'h0);
		rd(`EIRQ_OFF_IFLAG, r & 32'h1f, "rise");
		$display("test select done");
		check("irq", {31'h0, irq_out}, 32'h0);
		xfer(`EIRQ_OFF_EVMASK, 1'b1, 32'h1);
		check("irq", {31'h0, irq_out}, 32'h1);
		xfer(`EIRQ_OFF_EVSTAT, 1'b1, 32'h1);
		check("irq", {31'h0, irq_out}, 32'h0);
		rd(`EIRQ_OFF_EVSTAT, (r << 5) | (r & 32'h1e), "stat");
		$display("test irq done");
		for (int m = 1; m >= 0; m--) begin
			slow <= 1'($urandom);
			xfer(`EIRQ_OFF_WEDGE, 1'b1, {24'h0, {8{m[0]}}});
			xfer(`EIRQ_OFF_WFLAG, 1'b1, 32'h0);
			want <= {{8{m[0]}}, 5'h0};
			repeat (12) @(posedge pclk);
			rd(`EIRQ_OFF_WFLAG, r, "edge");
		end
		$display("test edge done");
		stop_test();
	end
endmodule // eirq_pin_flags_test
